/* hdl/pric_pkg.sv */
// pric_pkg: constants, register map and carrier types of the priority
// interrupt controller.
// assumes: one clock domain; users reference items as pric_pkg::name.
package pric_pkg;

  // ---------------------------------------------------------------
  // levels and widths
  // ---------------------------------------------------------------
  localparam int         VEC_W         = 7;
  localparam int         MAX_VECTOR    = 118;
  localparam int         LEVEL_W       = 4;
  localparam int         PRIO_W        = 3;
  localparam int         TIMED_DISABLE_INSTRUCTION_W        = 14;
  localparam logic [2:0] PRIO_RESET    = 3'h4;
  localparam logic [2:0] PRIO_OFF      = 3'h0;
  localparam logic [2:0] PRIO_TOP      = 3'h7;
  localparam logic [3:0] USER_TOP_LVL  = 4'h7;
  localparam logic [3:0] TRAP_BASE_LVL = 4'h8;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL1    = 8'h00;
  localparam logic [7:0] ADDR_FLAG     = 8'h04;
  localparam logic [7:0] ADDR_ENABLE   = 8'h08;
  localparam logic [7:0] ADDR_DBG_PRIO = 8'h0c;
  localparam logic [7:0] ADDR_PRIO     = 8'h10;
  localparam logic [7:0] ADDR_TEST     = 8'h14;
  localparam logic [7:0] ADDR_TIMED_DISABLE_INSTRUCTION     = 8'h18;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int NEST_DIS_BIT = 15;
  localparam int DBG_PRIO_LSB = 4;
  localparam int PRIO_STRIDE  = 4;
  localparam int UNACK_BIT    = 15;
  localparam int RSVD_BIT     = 14;
  localparam int VCAP_BIT     = 13;
  localparam int LEVEL_LSB    = 8;
  localparam int VEC_LSB      = 0;

  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              ack;
    logic              ret;
    logic [2:0]        sr_level;
    logic              timed_disable_instruction_start;
    logic [TIMED_DISABLE_INSTRUCTION_W-1:0] timed_disable_instruction_cycles;
  } pric_cpu_s;

  typedef struct packed {
    logic               req;
    logic [LEVEL_W-1:0] level;
    logic [VEC_W-1:0]   vector;
  } pric_req_s;

endpackage

/* hdl/pric_arbiter.sv */
// pric_arbiter: picks the highest level among valid candidates.
// assumes: candidate index equals its vector number; purely combinational.
module pric_arbiter #(
  parameter int N = 8
) (
  input  logic [N-1:0][3:0]             levels,
  input  logic [N-1:0]                  valid,
  output logic                          found,
  output logic [pric_pkg::VEC_W-1:0]    index,
  output logic [3:0]                    level
);

  if (N < 1 || N > pric_pkg::MAX_VECTOR + 1)
  begin : g_bad_n
    $error("pric_arbiter: candidate count out of range");
  end

  // scanning downward with >= leaves the lowest index among equals
  always_comb
  begin
    found = 1'b0;
    index = '0;
    level = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (valid[i] && (!found || levels[i] >= level))
      begin
        found = 1'b1;
        index = i[pric_pkg::VEC_W-1:0];
        level = levels[i];
      end
    end
  end

endmodule

/* hdl/pric_top.sv */
// pric_top: priority interrupt controller with classic wishbone registers,
// cpu request/acknowledge port, trap sources and a timed disable.
// assumes: cpu pulses ack only while req is high, ret once per return.
module pric_top #(
  parameter int NUM_SRC  = 8,
  parameter int NUM_TRAP = 4,
  parameter int DEPTH    = 16
) (
  input  logic                       clk,
  input  logic                       sys_rst,
  input  logic                       ce,
  input  logic                       wb_cyc_i,
  input  logic                       wb_stb_i,
  input  logic                       wb_we_i,
  input  logic [7:0]                 wb_adr_i,
  input  logic [3:0]                 wb_sel_i,
  input  logic [31:0]                wb_dat_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  input  logic [NUM_SRC-1:0]         src_event,
  input  logic [NUM_TRAP-1:0]        trap_event,
  input  pric_pkg::pric_cpu_s        cpu_in,
  output pric_pkg::pric_req_s        cpu_out,
  output logic [3:0]                 cpu_level_o,
  output logic                       irq_o
);

  localparam int NT = NUM_TRAP + NUM_SRC;
  localparam int DW = $clog2(DEPTH + 1);

  if (NUM_SRC < 1 || NUM_SRC > 8 || NUM_TRAP < 1 || NUM_TRAP > 8 || DEPTH < 1 ||
      NT > pric_pkg::MAX_VECTOR + 1)
  begin : g_bad_param
    $error("pric_top: unsupported parameter values");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [NUM_TRAP-1:0]            trap_flag;
    logic                           nest_dis;
    logic [NUM_SRC-1:0]             flag;
    logic [NUM_SRC-1:0]             enable;
    logic [NUM_SRC-1:0][2:0]        prio;
    logic                           vcap;
    logic [3:0]                     level;
    logic [DEPTH-1:0][3:0]          stack;
    logic [DW-1:0]                  depth;
    logic [pric_pkg::VEC_W-1:0]     last_vec;
    logic [pric_pkg::VEC_W-1:0]     shown_vec;
    logic [pric_pkg::TIMED_DISABLE_INSTRUCTION_W-1:0]    timed_disable_instruction_cnt;
    logic                           unacked;
    pric_pkg::pric_req_s            req;
    logic                           irq;
    logic                           ack;
    logic [31:0]                    dat;
  } pric_state_s;

  pric_state_s                  state_reg;
  pric_state_s                  state_next;
  logic [3:0]                   thr;
  logic [3:0]                   tos;
  logic [NT-1:0][3:0]           cand_lvl;
  logic [NT-1:0]                cand_pend;
  logic [NT-1:0]                cand_elig;
  logic                         pend_found;
  logic [pric_pkg::VEC_W-1:0]   pend_idx;
  logic                         elig_found;
  logic [pric_pkg::VEC_W-1:0]   elig_idx;
  logic [3:0]                   elig_lvl;
  logic                         bus_hit;
  logic [31:0]                  wmask;
  logic [31:0]                  wclr;
  logic [31:0]                  rdata;

  function automatic logic [31:0] byte_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++)
    begin
      m[8*b +: 8] = {8{sel[b]}};
    end
    return m;
  endfunction

  // ---------------------------------------------------------------
  // candidates and threshold
  // ---------------------------------------------------------------
  always_comb
  begin
    thr = (state_reg.level > {1'b0, cpu_in.sr_level}) ?
          state_reg.level : {1'b0, cpu_in.sr_level};
    // an open service with nesting off acts as the top user level
    if (state_reg.nest_dis && state_reg.depth != '0 && thr < pric_pkg::USER_TOP_LVL)
      thr = pric_pkg::USER_TOP_LVL;
    for (int t = 0; t < NUM_TRAP; t++)
    begin
      cand_lvl[t]  = pric_pkg::TRAP_BASE_LVL + t[3:0];
      cand_pend[t] = state_reg.trap_flag[t];
      cand_elig[t] = state_reg.trap_flag[t] && cand_lvl[t] > thr;
    end
    for (int j = 0; j < NUM_SRC; j++)
    begin
      cand_lvl[NUM_TRAP+j]  = {1'b0, state_reg.prio[j]};
      cand_pend[NUM_TRAP+j] = state_reg.flag[j] && state_reg.enable[j] &&
                              state_reg.prio[j] != pric_pkg::PRIO_OFF;
      cand_elig[NUM_TRAP+j] = cand_pend[NUM_TRAP+j] && cand_lvl[NUM_TRAP+j] > thr &&
                              !(state_reg.timed_disable_instruction_cnt != '0 &&
                                state_reg.prio[j] != pric_pkg::PRIO_TOP);
    end
    tos = '0;
    for (int k = 0; k < DEPTH; k++)
    begin
      if (k + 1 == int'(state_reg.depth))
        tos = state_reg.stack[k];
    end
  end

  pric_arbiter #(.N(NT)) u_pend_arb (
    .levels (cand_lvl),
    .valid  (cand_pend),
    .found  (pend_found),
    .index  (pend_idx),
    .level  ()
  );

  pric_arbiter #(.N(NT)) u_elig_arb (
    .levels (cand_lvl),
    .valid  (cand_elig),
    .found  (elig_found),
    .index  (elig_idx),
    .level  (elig_lvl)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    state_next     = state_reg;
    bus_hit        = wb_cyc_i && wb_stb_i && !state_reg.ack;
    wmask          = byte_mask(wb_sel_i);
    wclr           = wb_dat_i & wmask;
    state_next.ack = bus_hit;
    if (bus_hit && wb_we_i)
    begin
      case (wb_adr_i)
        pric_pkg::ADDR_CTRL1:
        begin
          if (wmask[pric_pkg::NEST_DIS_BIT])
            state_next.nest_dis = wb_dat_i[pric_pkg::NEST_DIS_BIT];
          state_next.trap_flag = state_reg.trap_flag & ~wclr[NUM_TRAP-1:0];
        end
        pric_pkg::ADDR_FLAG:
          state_next.flag = state_reg.flag & ~wclr[NUM_SRC-1:0];
        pric_pkg::ADDR_ENABLE:
          state_next.enable = (state_reg.enable & ~wmask[NUM_SRC-1:0]) |
                              (wb_dat_i[NUM_SRC-1:0] & wmask[NUM_SRC-1:0]);
        pric_pkg::ADDR_DBG_PRIO:
          state_next.prio[0] = (state_reg.prio[0] & ~wmask[pric_pkg::DBG_PRIO_LSB +: 3]) |
                               wclr[pric_pkg::DBG_PRIO_LSB +: 3];
        pric_pkg::ADDR_PRIO:
        begin
          for (int j = 1; j < NUM_SRC; j++)
          begin
            state_next.prio[j] = (state_reg.prio[j] & ~wmask[pric_pkg::PRIO_STRIDE*j +: 3]) |
                                 wclr[pric_pkg::PRIO_STRIDE*j +: 3];
          end
        end
        pric_pkg::ADDR_TEST:
        begin
          // reserved bit is not stored, so a stray one never sticks
          if (wmask[pric_pkg::VCAP_BIT])
            state_next.vcap = wb_dat_i[pric_pkg::VCAP_BIT];
        end
        default: ;
      endcase
    end
    // hardware set is applied after the software clear so it wins
    state_next.flag      = state_next.flag | src_event;
    state_next.trap_flag = state_next.trap_flag | trap_event;

    rdata = '0;
    case (wb_adr_i)
      pric_pkg::ADDR_CTRL1:
      begin
        rdata[pric_pkg::NEST_DIS_BIT] = state_reg.nest_dis;
        rdata[NUM_TRAP-1:0]           = state_reg.trap_flag;
      end
      pric_pkg::ADDR_FLAG:
        rdata[NUM_SRC-1:0] = state_reg.flag;
      pric_pkg::ADDR_ENABLE:
        rdata[NUM_SRC-1:0] = state_reg.enable;
      pric_pkg::ADDR_DBG_PRIO:
        rdata[pric_pkg::DBG_PRIO_LSB +: 3] = state_reg.prio[0];
      pric_pkg::ADDR_PRIO:
      begin
        for (int j = 1; j < NUM_SRC; j++)
        begin
          rdata[pric_pkg::PRIO_STRIDE*j +: 3] = state_reg.prio[j];
        end
      end
      pric_pkg::ADDR_TEST:
      begin
        rdata[pric_pkg::UNACK_BIT]                     = state_reg.unacked;
        rdata[pric_pkg::VCAP_BIT]                      = state_reg.vcap;
        rdata[pric_pkg::LEVEL_LSB +: 4]                = state_reg.level;
        rdata[pric_pkg::VEC_LSB +: pric_pkg::VEC_W]    = state_reg.shown_vec;
      end
      pric_pkg::ADDR_TIMED_DISABLE_INSTRUCTION:
        rdata[pric_pkg::TIMED_DISABLE_INSTRUCTION_W-1:0] = state_reg.timed_disable_instruction_cnt;
      default:
        rdata = '0;
    endcase
    state_next.dat = (bus_hit && !wb_we_i) ? rdata : '0;

    // acknowledge stacks the old level; return pops it
    if (cpu_in.ack && state_reg.req.req)
    begin
      for (int k = 0; k < DEPTH; k++)
      begin
        if (k == int'(state_reg.depth))
        begin
          state_next.stack[k] = state_reg.level;
        end
      end
      state_next.depth    = state_reg.depth + 1'b1;
      state_next.level    = state_reg.req.level;
      state_next.last_vec = state_reg.req.vector;
    end
    else if (cpu_in.ret && state_reg.depth != '0)
    begin
      state_next.level = tos;
      state_next.depth = state_reg.depth - 1'b1;
    end

    if (cpu_in.timed_disable_instruction_start)
      state_next.timed_disable_instruction_cnt = cpu_in.timed_disable_instruction_cycles;
    else if (state_reg.timed_disable_instruction_cnt != '0)
      state_next.timed_disable_instruction_cnt = state_reg.timed_disable_instruction_cnt - 1'b1;

    // request drops for one cycle after an ack so the raised level is seen
    state_next.req.req    = elig_found && !(cpu_in.ack && state_reg.req.req) &&
                            int'(state_reg.depth) < DEPTH;
    state_next.req.level  = elig_lvl;
    state_next.req.vector = elig_idx;
    state_next.unacked    = pend_found && !elig_found;
    state_next.shown_vec  = state_next.vcap ? pend_idx : state_next.last_vec;
    state_next.irq        = |(state_next.flag & state_next.enable);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg      <= '0;
      state_reg.prio <= {NUM_SRC{pric_pkg::PRIO_RESET}};
    end
    else if (ce)
    begin
      state_reg <= state_next;
    end
  end

  assign wb_dat_o    = state_reg.dat;
  assign wb_ack_o    = state_reg.ack;
  assign cpu_out     = state_reg.req;
  assign cpu_level_o = state_reg.level;
  assign irq_o       = state_reg.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_dbg_zero;
    @(posedge clk) disable iff (sys_rst)
    (wb_ack_o && !wb_we_i && wb_adr_i == pric_pkg::ADDR_DBG_PRIO) |->
      (wb_dat_o & ~32'h0000_0070) == 32'h0000_0000;
  endproperty
  a_dbg_zero: assert property (p_dbg_zero)
    else $error("debug priority register shows unimplemented bits");

  property p_prio_reset;
    @(posedge clk) disable iff (sys_rst)
    $fell(sys_rst) |-> state_reg.prio == {NUM_SRC{3'h4}};
  endproperty
  a_prio_reset: assert property (p_prio_reset)
    else $error("priority fields not at level 4 after reset");

  property p_unacked_no_req;
    @(posedge clk) disable iff (sys_rst)
    state_reg.unacked |-> !cpu_out.req;
  endproperty
  a_unacked_no_req: assert property (p_unacked_no_req)
    else $error("held-off flag set while a request is presented");

  property p_vcap_live;
    @(posedge clk) disable iff (sys_rst)
    (ce && state_next.vcap) |=> state_reg.shown_vec == $past(pend_idx);
  endproperty
  a_vcap_live: assert property (p_vcap_live)
    else $error("vector field does not follow highest pending");

  property p_vec_hold;
    @(posedge clk) disable iff (sys_rst)
    (ce && cpu_in.ack && cpu_out.req && !state_reg.vcap && !bus_hit) |=>
      state_reg.shown_vec == $past(cpu_out.vector);
  endproperty
  a_vec_hold: assert property (p_vec_hold)
    else $error("vector field lost the acknowledged vector");

  property p_level_read;
    @(posedge clk) disable iff (sys_rst)
    (wb_ack_o && !wb_we_i && wb_adr_i == pric_pkg::ADDR_TEST) |->
      wb_dat_o[11:8] == $past(state_reg.level) && wb_dat_o[14] == 1'b0;
  endproperty
  a_level_read: assert property (p_level_read)
    else $error("test register level field wrong");

  property p_vec_range;
    @(posedge clk) disable iff (sys_rst)
    cpu_out.vector <= 7'h76 && state_reg.shown_vec <= 7'h76;
  endproperty
  a_vec_range: assert property (p_vec_range)
    else $error("vector number above 118");

  property p_nest;
    @(posedge clk) disable iff (sys_rst)
    (ce && state_reg.nest_dis && state_reg.depth != '0) |=>
      !(cpu_out.req && cpu_out.level <= 4'h7);
  endproperty
  a_nest: assert property (p_nest)
    else $error("user request preempts with nesting disabled");

  property p_return;
    @(posedge clk) disable iff (sys_rst)
    (ce && cpu_in.ret && !(cpu_in.ack && cpu_out.req) && state_reg.depth != '0) |=>
      cpu_level_o == $past(tos);
  endproperty
  a_return: assert property (p_return)
    else $error("return did not restore stacked level");

  property p_mask7;
    @(posedge clk) disable iff (sys_rst)
    (ce && cpu_in.sr_level == 3'h7) |=> !(cpu_out.req && cpu_out.level <= 4'h7);
  endproperty
  a_mask7: assert property (p_mask7)
    else $error("user request passes level 7 mask");

  property p_timed_disable_instruction;
    @(posedge clk) disable iff (sys_rst)
    (ce && state_reg.timed_disable_instruction_cnt != '0) |=>
      !(cpu_out.req && cpu_out.level >= 4'h1 && cpu_out.level <= 4'h6);
  endproperty
  a_timed_disable_instruction: assert property (p_timed_disable_instruction)
    else $error("level 1-6 request during timed disable");

  property p_no_zero_req;
    @(posedge clk) disable iff (sys_rst)
    cpu_out.req |-> cpu_out.level != 4'h0;
  endproperty
  a_no_zero_req: assert property (p_no_zero_req)
    else $error("request presented at priority 0");

endmodule

/* tb/pric_cpu_model.sv */
// pric_cpu_model: behavioural cpu core that takes offered requests and returns.
// assumes: controller request is registered; accept stalls come from the bench.
module pric_cpu_model #(
  parameter int SVC = 40
) (
  input  logic                clk,
  input  logic                sys_rst,
  input  logic                accept,
  input  pric_pkg::pric_req_s cpu_out,
  output logic                ack,
  output logic                ret
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [6:0] log_q[$];
  int         open_cnt;
  int         tmr;
  logic       ret_due;

  // a return is never issued beside an ack: the ack would win and the return be lost
  assign ret_due = !(ack && cpu_out.req) && tmr <= 1 && open_cnt > 0;

  // ---------------------------------------------------------------
  // take and service
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ack <= 1'b0;
      ret <= 1'b0;
      open_cnt <= 0;
      tmr <= 0;
    end
    else
    begin
      ack <= cpu_out.req && !ack && accept && !ret_due;
      ret <= ret_due;
      if (ack && cpu_out.req)
      begin
        log_q.push_back(cpu_out.vector);
        open_cnt <= open_cnt + 1;
        tmr <= SVC;
      end
      else if (tmr > 1)
        tmr <= tmr - 1;
      else if (ret_due)
      begin
        open_cnt <= open_cnt - 1;
        tmr <= SVC;
      end
    end
  end
endmodule

/* tb/testbench.sv */
// testbench: drives registers over wishbone, sources, traps and cpu fields.
// assumes: pric_top with 8 sources and 4 traps; cpu model answers requests.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic                clk = 1'b0;
  logic                sys_rst;
  logic                ce;
  logic                cyc;
  logic                stb;
  logic                we;
  logic [7:0]          adr;
  logic [31:0]         dat;
  logic [31:0]         dat_o;
  logic                wb_ack;
  logic [7:0]          src;
  logic [3:0]          trap;
  pric_pkg::pric_cpu_s cpu_in;
  pric_pkg::pric_req_s cpu_out;
  logic [3:0]          lvl;
  logic                irq;
  logic                p_ack;
  logic                p_ret;
  logic                accept;
  logic                hold;
  logic [2:0]          sr;
  logic                ds;
  logic [13:0]         dc;
  logic [7:0]          seed = 8'h26;
  logic [31:0]         r;
  int                  num_errors;
  int                  compares;
  int                  nlog;

  assign cpu_in = '{ack: p_ack, ret: p_ret, sr_level: sr, timed_disable_instruction_start: ds, timed_disable_instruction_cycles: dc};

  pric_top #(.NUM_SRC(8), .NUM_TRAP(4), .DEPTH(16)) dut (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(wb_ack), .src_event(src), .trap_event(trap), .cpu_in(cpu_in),
    .cpu_out(cpu_out), .cpu_level_o(lvl), .irq_o(irq));

  pric_cpu_model u_cpu (.clk(clk), .sys_rst(sys_rst), .accept(accept),
    .cpu_out(cpu_out), .ack(p_ack), .ret(p_ret));

  // ---------------------------------------------------------------
  // clock and random stalls
  // ---------------------------------------------------------------
  always #2.5 clk = ~clk;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  always @(posedge clk)
  begin
    seed <= lfsr(seed);
    accept <= !hold && (seed[0] | seed[1]);
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk);
    // only the watchdog ends a wait for the answer
    while (wb_ack !== 1'b1)
      @(posedge clk);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task ev(input logic [7:0] s, input logic [3:0] t);
    @(posedge clk);
    src <= s;
    trap <= t;
    @(posedge clk);
    src <= 8'h00;
    trap <= 4'h0;
  endtask

  // waits for the next acknowledged request and checks its vector
  // polled on the falling edge so the log and the raised level are settled
  task take(input logic [6:0] v);
    while (u_cpu.log_q.size() <= nlog)
      @(negedge clk);
    chk({25'h0, u_cpu.log_q[nlog]}, {25'h0, v});
    nlog++;
  endtask

  task conclude();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #50000;
    num_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    conclude();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    ce = 1'b1;
    {cyc, stb, we, adr, dat, src, trap, sr, ds, dc} = '0;
    {hold, num_errors, compares, nlog} = '0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rd(pric_pkg::ADDR_DBG_PRIO, 32'h40);
    rd(pric_pkg::ADDR_PRIO, 32'h44444440);
    rd(pric_pkg::ADDR_TEST, 32'h0);
    rd(8'h40, 32'h0);
    r = {4{seed}};
    wr(pric_pkg::ADDR_DBG_PRIO, r);
    rd(pric_pkg::ADDR_DBG_PRIO, r & 32'h70);
    $display("register test done");
    wr(pric_pkg::ADDR_DBG_PRIO, 32'h70);
    wr(pric_pkg::ADDR_FLAG, 32'hff);
    wr(pric_pkg::ADDR_ENABLE, 32'h1);
    ev(8'h01, 4'h0);
    take(7'h04);
    chk(lvl, 4'h7);
    rd(pric_pkg::ADDR_TEST, 32'h8704);
    take(7'h04);
    hold <= 1'b1;
    wr(pric_pkg::ADDR_FLAG, 32'h1);
    wr(pric_pkg::ADDR_ENABLE, 32'h0);
    repeat (100) @(posedge clk);
    chk(lvl, 4'h0);
    ev(8'h02, 4'h0);
    rd(pric_pkg::ADDR_FLAG, 32'h2);
    chk(irq, 1'b0);
    wr(pric_pkg::ADDR_ENABLE, 32'h2);
    chk(irq, 1'b1);
    wr(pric_pkg::ADDR_FLAG, 32'h2);
    chk(irq, 1'b0);
    $display("service test done");
    wr(pric_pkg::ADDR_PRIO, 32'h44444330);
    wr(pric_pkg::ADDR_ENABLE, 32'h6);
    ev(8'h06, 4'h0);
    hold <= 1'b0;
    take(7'h05);
    wr(pric_pkg::ADDR_FLAG, 32'h2);
    take(7'h06);
    wr(pric_pkg::ADDR_FLAG, 32'h4);
    repeat (100) @(posedge clk);
    $display("tie test done");
    sr <= 3'h7;
    wr(pric_pkg::ADDR_ENABLE, 32'h1);
    ev(8'h01, 4'h0);
    repeat (10) @(posedge clk);
    chk(cpu_out.req, 1'b0);
    wr(pric_pkg::ADDR_TEST, 32'h2000);
    rd(pric_pkg::ADDR_TEST, 32'ha004);
    ev(8'h00, 4'h2);
    take(7'h01);
    chk(lvl, 4'h9);
    take(7'h01);
    wr(pric_pkg::ADDR_CTRL1, 32'h2);
    wr(pric_pkg::ADDR_FLAG, 32'h1);
    wr(pric_pkg::ADDR_TEST, 32'h0);
    sr <= 3'h0;
    repeat (100) @(posedge clk);
    chk(32'(u_cpu.log_q.size()), 32'(nlog));
    $display("mask test done");
    wr(pric_pkg::ADDR_PRIO, 32'h44444460);
    wr(pric_pkg::ADDR_ENABLE, 32'h3);
    ds <= 1'b1;
    dc <= 14'h3c;
    @(posedge clk);
    ds <= 1'b0;
    ev(8'h02, 4'h0);
    repeat (20) @(posedge clk);
    chk(32'(u_cpu.log_q.size()), 32'(nlog));
    ev(8'h01, 4'h0);
    take(7'h04);
    wr(pric_pkg::ADDR_FLAG, 32'h1);
    take(7'h05);
    wr(pric_pkg::ADDR_FLAG, 32'h2);
    repeat (100) @(posedge clk);
    $display("timed disable test done");
    wr(pric_pkg::ADDR_CTRL1, 32'h8000);
    ev(8'h02, 4'h0);
    take(7'h05);
    ev(8'h01, 4'h0);
    repeat (10) @(posedge clk);
    chk(32'(u_cpu.log_q.size()), 32'(nlog));
    wr(pric_pkg::ADDR_FLAG, 32'h2);
    take(7'h04);
    wr(pric_pkg::ADDR_FLAG, 32'h1);
    $display("nesting test done");
    // an event seen while the enable is low must be lost
    ce <= 1'b0;
    ev(8'h04, 4'h0);
    ce <= 1'b1;
    rd(pric_pkg::ADDR_FLAG, 32'h0);
    $display("clock enable test done");
    conclude();
  end
endmodule
